/* core/cid_consts.svh */
// Overview of operation
// - Program counter changes take two cycles; the second cycle idles.
// - Indirect access to an address with its top bit set adds one cycle.
// - 0x000B branches relative by the accumulator, two cycles.
// - 0x000A calls a subroutine whose low target byte is the accumulator.
// - 0x0009 is the interrupt exit, two cycles.
// - 0x34kk exits a subroutine loading the literal into the accumulator.
// - 0x0008 is a plain subroutine exit, two cycles.
// - 0x0064 clears the watchdog in one cycle, setting expiry and power-down flags.
// - 0x0062 copies the accumulator into the prescaler configuration register.
// - 0x0001 requests a software reset of the whole device.
// - 0x0063 enters standby in one cycle, updating expiry and power-down flags.
// - 0x006f copies the accumulator into direction register f.
// - 0x310x/0x314x adds a literal to pointer n, flags untouched.
// - Pointer-add literal is signed six bits, added to the full pointer.
// - Pointer arithmetic wraps modulo 16 bits.
// - 0x001x loads accumulator through pointer n with inc/dec modifier, updating zero.
// - 0x3F0x loads accumulator from pointer n plus offset, updating zero.
// - Store of accumulator through pointer n with modifier, flags untouched.
// - 0x3F8x stores accumulator at pointer n plus offset.
// - And-literal ands accumulator with literal, updates zero only.
// - Add-literal adds literal to accumulator, updates carry, digit carry, zero.
// - And-file ands accumulator with f; d picks accumulator or f; updates zero.
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH

// Decode masks
`define CID_M_FULL 14'h3FFF
`define CID_M_LOW3 14'h3FF8
`define CID_M_PTR 14'h3F80
`define CID_M_LIT 14'h3F00

// Opcode patterns
`define CID_OP_IDLE 14'h0000
`define CID_OP_RESET 14'h0001
`define CID_OP_RETURN 14'h0008
`define CID_OP_IEXIT 14'h0009
`define CID_OP_CALLACC 14'h000A
`define CID_OP_BRACC 14'h000B
`define CID_OP_LOAD 14'h0010
`define CID_OP_STORE 14'h0018
`define CID_OP_DIR 14'h0060
`define CID_OP_OPTION 14'h0062
`define CID_OP_SLEEP 14'h0063
`define CID_OP_WDCLR 14'h0064
`define CID_OP_ANDF 14'h0500
`define CID_OP_PTRADD 14'h3100
`define CID_OP_LEXIT 14'h3400
`define CID_OP_ANDLIT 14'h3900
`define CID_OP_ADDLIT 14'h3E00
`define CID_OP_IDXLD 14'h3F00
`define CID_OP_IDXST 14'h3F80

// Field positions
`define CID_F_DEST 7
`define CID_F_NPTR 6
`define CID_F_NINC 2
`define CID_F_NWIN 0

// Pointer modifier codes
`define CID_MM_PREINC 2'h0
`define CID_MM_PREDEC 2'h1
`define CID_MM_POSTINC 2'h2
`define CID_MM_POSTDEC 2'h3

// Instruction cycle phases
`define CID_PH_FETCH 2'h0
`define CID_PH_ADDR 2'h1
`define CID_PH_READ 2'h2
`define CID_PH_WB 2'h3

// Status bit positions and reset values
`define CID_SB_C 0
`define CID_SB_DC 1
`define CID_SB_Z 2
`define CID_SB_PWD 3
`define CID_SB_EXP 4
`define CID_STATUS_RST 5'h18
`define CID_W_RST 8'h00
`define CID_OPTION_RST 8'hFF
`define CID_WIN_HI 6'h00

`endif

/* core/cid_pkg.sv */
package cid_pkg;

    typedef enum logic [1:0] {
        cid_st_exec = 2'b00,
        cid_st_stall = 2'b01,
        cid_st_flush = 2'b10
    } cid_state_e;

    typedef logic [13:0] cid_word_t;

    function automatic logic cid_match(
        input cid_word_t word,
        input cid_word_t mask,
        input cid_word_t pat
    );
        return (word & mask) == pat;
    endfunction

endpackage

/* core/cid_ptr_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cid_consts.svh"
module cid_ptr_unit
    import cid_pkg::*;
#(
    parameter int PW = 16
) (
    // Selected pointer
    input wire logic [PW-1:0] ptr,
    // Access shape
    input wire logic idx,
    input wire logic [1:0] mode,
    input wire logic [5:0] ofs,
    // Results
    output logic [PW-1:0] ea,
    output logic [PW-1:0] step,
    output logic [PW-1:0] sum
);
    logic [PW-1:0] ofs_x;
    logic [PW-1:0] inc_v;
    logic [PW-1:0] dec_v;
    logic pre_inc;
    logic pre_dec;
    logic up;

    assign ofs_x = {{(PW-6){ofs[5]}}, ofs};
    assign sum = ptr + ofs_x;
    assign inc_v = ptr + PW'(1);
    assign dec_v = ptr - PW'(1);
    assign pre_inc = (mode == `CID_MM_PREINC);
    assign pre_dec = (mode == `CID_MM_PREDEC);
    assign up = pre_inc || (mode == `CID_MM_POSTINC);
    // Pre modes access the updated pointer, post modes the old one
    assign ea = idx ? sum : (pre_inc ? inc_v : (pre_dec ? dec_v : ptr));
    assign step = up ? inc_v : dec_v;
endmodule
`default_nettype wire

/* core/cid_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cid_consts.svh"
module cid_core
    import cid_pkg::*;
#(
    parameter int PC_W = 15,
    parameter int PTR_W = 16,
    parameter int STK_DEPTH = 16,
    parameter int SP_W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Program memory
    input wire logic [13:0] prog_word,
    input wire logic prog_valid,
    output logic [PC_W-1:0] prog_addr,
    output logic inst_take,
    // Data memory
    input wire logic [7:0] dm_rdata,
    output logic [PTR_W-1:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output logic [7:0] dm_wdata,
    // Core state
    output logic [7:0] w_out,
    output logic [4:0] status_out,
    output logic [7:0] option_out,
    output logic [PTR_W-1:0] ptr0_out,
    output logic [PTR_W-1:0] ptr1_out,
    // Side effects
    output logic dir_wr,
    output logic [2:0] dir_sel,
    output logic [7:0] dir_data,
    output logic wdt_clr,
    output logic sleep_req,
    output logic soft_rst,
    output logic gie_set
);
    cid_state_e st_r;
    cid_state_e st_nxt;
    logic [1:0] q_r;
    logic [1:0] q_nxt;
    cid_word_t inst_r;
    logic [PC_W-1:0] stk [STK_DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [SP_W-1:0] sp_dec;

    // Phase and fetch control
    logic live;
    logic ph_fetch;
    logic ph_addr;
    logic ph_read;
    logic ph_wb;
    logic hold;
    logic fetch_go;

    assign live = (st_r == cid_st_exec);
    assign ph_fetch = (q_r == `CID_PH_FETCH);
    assign ph_addr = (q_r == `CID_PH_ADDR);
    assign ph_read = (q_r == `CID_PH_READ);
    assign ph_wb = (q_r == `CID_PH_WB);
    assign hold = ph_fetch && live && !prog_valid;
    assign fetch_go = ph_fetch && live && prog_valid;
    assign q_nxt = hold ? q_r : q_r + 2'h1;

    // Instruction decode
    logic is_bracc;
    logic is_callacc;
    logic is_iexit;
    logic is_lexit;
    logic is_return;
    logic is_wdclr;
    logic is_option;
    logic is_reset;
    logic is_sleep;
    logic is_dir;
    logic is_ptradd;
    logic is_load;
    logic is_idxld;
    logic is_store;
    logic is_idxst;
    logic is_andlit;
    logic is_addlit;
    logic is_andf;

    assign is_bracc = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_BRACC);
    assign is_callacc = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_CALLACC);
    assign is_iexit = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_IEXIT);
    assign is_lexit = live && cid_match(inst_r, `CID_M_LIT, `CID_OP_LEXIT);
    assign is_return = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_RETURN);
    assign is_wdclr = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_WDCLR);
    assign is_option = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_OPTION);
    assign is_reset = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_RESET);
    assign is_sleep = live && cid_match(inst_r, `CID_M_FULL, `CID_OP_SLEEP);
    // Direction loads share their range with three inherent ops
    assign is_dir = live && cid_match(inst_r, `CID_M_LOW3, `CID_OP_DIR)
        && !is_option && !is_sleep && !is_wdclr;
    assign is_ptradd = live && cid_match(inst_r, `CID_M_PTR, `CID_OP_PTRADD);
    assign is_load = live && cid_match(inst_r, `CID_M_LOW3, `CID_OP_LOAD);
    assign is_idxld = live && cid_match(inst_r, `CID_M_PTR, `CID_OP_IDXLD);
    assign is_store = live && cid_match(inst_r, `CID_M_LOW3, `CID_OP_STORE);
    assign is_idxst = live && cid_match(inst_r, `CID_M_PTR, `CID_OP_IDXST);
    assign is_andlit = live && cid_match(inst_r, `CID_M_LIT, `CID_OP_ANDLIT);
    assign is_addlit = live && cid_match(inst_r, `CID_M_LIT, `CID_OP_ADDLIT);
    assign is_andf = live && cid_match(inst_r, `CID_M_LIT, `CID_OP_ANDF);

    // Pointer selection and addressing
    logic by_ptr_field;
    logic by_inc_field;
    logic n_sel;
    logic win_hit;
    logic acc_ind;
    logic [PTR_W-1:0] ptr_sel;
    logic [PTR_W-1:0] ea;
    logic [PTR_W-1:0] step;
    logic [PTR_W-1:0] sum;
    logic [PTR_W-1:0] acc_addr;

    assign by_ptr_field = is_ptradd || is_idxld || is_idxst;
    assign by_inc_field = is_load || is_store;
    assign n_sel = by_ptr_field ? inst_r[`CID_F_NPTR]
        : (by_inc_field ? inst_r[`CID_F_NINC] : inst_r[`CID_F_NWIN]);
    assign ptr_sel = n_sel ? ptr1_out : ptr0_out;
    // File 0 and 1 are the indirect windows
    assign win_hit = is_andf && (inst_r[6:1] == `CID_WIN_HI);
    assign acc_ind = win_hit || by_inc_field || is_idxld || is_idxst;
    // Windows use the pointer as it stands, with no modifier
    assign acc_addr = win_hit ? ptr_sel : (acc_ind ? ea : {{(PTR_W-7){1'b0}}, inst_r[6:0]});

    cid_ptr_unit #(
        .PW(PTR_W)
    ) u_ptr (
        .ptr(ptr_sel),
        .idx(is_idxld || is_idxst),
        .mode(inst_r[1:0]),
        .ofs(inst_r[5:0]),
        .ea(ea),
        .step(step),
        .sum(sum)
    );

    // Data path
    logic dest_f;
    logic need_read;
    logic put_w;
    logic and_wr;
    logic [7:0] lit;
    logic [7:0] and_res;
    logic [8:0] add9;
    logic [4:0] add5;
    logic [7:0] alu_res;
    logic alu_we;
    logic w_we;
    logic z_we;

    assign dest_f = inst_r[`CID_F_DEST];
    assign lit = inst_r[7:0];
    assign need_read = is_andf || is_load || is_idxld;
    assign put_w = is_store || is_idxst;
    assign and_wr = is_andf && dest_f;
    assign and_res = w_out & dm_rdata;
    assign add9 = {1'b0, w_out} + {1'b0, lit};
    assign add5 = {1'b0, w_out[3:0]} + {1'b0, lit[3:0]};
    assign alu_res = is_andlit ? (w_out & lit)
        : (is_addlit ? add9[7:0]
        : (is_andf ? and_res : dm_rdata));
    assign alu_we = is_andlit || is_addlit || need_read;
    assign w_we = alu_we && !and_wr;
    assign z_we = alu_we;

    // Control flow
    logic pc_chg;
    logic pop;
    logic need_stall;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] bracc_tgt;
    logic [PC_W-1:0] callacc_tgt;
    logic [PC_W-1:0] pc_tgt;

    assign pop = is_iexit || is_lexit || is_return;
    assign pc_chg = is_bracc || is_callacc || pop;
    // Address latched in phase 1, before any pointer update moves it
    assign need_stall = acc_ind && dm_addr[PTR_W-1];
    assign sp_dec = sp_r - SP_W'(1);
    assign pc_inc = prog_addr + PC_W'(1);
    // Counter already points past this op
    assign bracc_tgt = prog_addr + {{(PC_W-8){1'b0}}, w_out};
    assign callacc_tgt = {prog_addr[PC_W-1:8], w_out};
    assign pc_tgt = is_bracc ? bracc_tgt : (is_callacc ? callacc_tgt : stk[sp_dec]);

    always_comb begin
        st_nxt = st_r;
        if (ph_wb) begin
            if (!live) begin
                st_nxt = cid_st_exec;
            end else if (pc_chg) begin
                st_nxt = cid_st_flush;
            end else if (need_stall) begin
                st_nxt = cid_st_stall;
            end else begin
                st_nxt = cid_st_exec;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q_r <= `CID_PH_FETCH;
            st_r <= cid_st_exec;
        end else begin
            q_r <= q_nxt;
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inst_r <= `CID_OP_IDLE;
            inst_take <= 1'b0;
        end else begin
            inst_take <= fetch_go;
            if (fetch_go) begin
                inst_r <= prog_word;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prog_addr <= '0;
            sp_r <= '0;
        end else if (fetch_go) begin
            prog_addr <= pc_inc;
        end else if (ph_wb && pc_chg) begin
            prog_addr <= pc_tgt;
            if (is_callacc) begin
                sp_r <= sp_r + SP_W'(1);
            end else if (pop) begin
                sp_r <= sp_dec;
            end
        end
    end

    // Return stack body, no reset needed
    always_ff @(posedge core_clk) begin
        if (ph_wb && is_callacc) begin
            stk[sp_r] <= prog_addr;
        end
    end

    // Data memory strobes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dm_addr <= '0;
            dm_rd <= 1'b0;
            dm_wr <= 1'b0;
            dm_wdata <= `CID_W_RST;
        end else begin
            dm_rd <= ph_addr && need_read;
            dm_wr <= (ph_addr && put_w) || (ph_read && and_wr);
            if (ph_addr) begin
                dm_addr <= acc_addr;
                dm_wdata <= w_out;
            end else if (ph_read && and_wr) begin
                dm_wdata <= and_res;
            end
        end
    end

    // Accumulator and flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            w_out <= `CID_W_RST;
        end else if (ph_read && w_we) begin
            w_out <= alu_res;
        end else if (ph_wb && is_lexit) begin
            w_out <= lit;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_out <= `CID_STATUS_RST;
        end else if (ph_read) begin
            if (z_we) begin
                status_out[`CID_SB_Z] <= (alu_res == 8'h00);
            end
            if (is_addlit) begin
                status_out[`CID_SB_C] <= add9[8];
                status_out[`CID_SB_DC] <= add5[4];
            end
            if (is_wdclr || is_sleep) begin
                status_out[`CID_SB_EXP] <= 1'b1;
                status_out[`CID_SB_PWD] <= is_wdclr;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            option_out <= `CID_OPTION_RST;
        end else if (ph_read && is_option) begin
            option_out <= w_out;
        end
    end

    // Pointer updates leave the flags alone
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr0_out <= '0;
            ptr1_out <= '0;
        end else if (ph_read && (is_ptradd || by_inc_field)) begin
            if (n_sel) begin
                ptr1_out <= is_ptradd ? sum : step;
            end else begin
                ptr0_out <= is_ptradd ? sum : step;
            end
        end
    end

    // One-clock side effect pulses
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dir_wr <= 1'b0;
            dir_sel <= 3'h0;
            dir_data <= `CID_W_RST;
            wdt_clr <= 1'b0;
            sleep_req <= 1'b0;
            soft_rst <= 1'b0;
            gie_set <= 1'b0;
        end else begin
            dir_wr <= ph_read && is_dir;
            wdt_clr <= ph_read && is_wdclr;
            sleep_req <= ph_read && is_sleep;
            soft_rst <= ph_read && is_reset;
            gie_set <= ph_wb && is_iexit;
            if (ph_read && is_dir) begin
                dir_sel <= inst_r[2:0];
                dir_data <= w_out;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/cid_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cid_monitor
    import cid_pkg::*;
#(
    parameter int PTR_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Fetch
    input wire logic [13:0] prog_word,
    input wire logic inst_take,
    // Data side
    input wire logic [PTR_W-1:0] dm_addr,
    input wire logic dm_rd,
    input wire logic dm_wr,
    // Core state
    input wire logic [7:0] w_out,
    input wire logic [4:0] status_out,
    input wire logic [7:0] option_out,
    input wire logic [PTR_W-1:0] ptr0_out,
    input wire logic [PTR_W-1:0] ptr1_out,
    // Side effects
    input wire logic dir_wr,
    input wire logic [2:0] dir_sel,
    input wire logic [7:0] dir_data,
    input wire logic wdt_clr,
    input wire logic sleep_req
);
    logic [13:0] word_r;
    logic [13:0] lat_r;
    wire logic pc_op = word_r[13:2] == 12'h002 || word_r[13:8] == 6'h34;
    wire logic dir_op = word_r[13:3] == 11'h00C && !(word_r[2:0] inside {3'h2, 3'h3, 3'h4});
    // Word taken at the edge before inst_take; held for the result phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            word_r <= 14'h0000;
            lat_r <= 14'h0000;
        end else begin
            word_r <= prog_word;
            if (inst_take) lat_r <= word_r;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    flush_cycle_a: assert property (inst_take && pc_op |=> !inst_take [*7])
        else $error("pc change without idle cycle");
    stall_cycle_a: assert property (inst_take ##1 ((dm_rd || dm_wr) && dm_addr[PTR_W-1])
        |=> !inst_take [*6]) else $error("missing stall cycle");
    option_load_a: assert property (inst_take && word_r == 14'h0062 |-> ##2
        option_out == w_out) else $error("option not loaded");
    dir_write_a: assert property (inst_take && dir_op |-> ##2 dir_wr &&
        dir_sel == lat_r[2:0] && dir_data == w_out) else $error("direction write wrong");
    wdt_clear_a: assert property (inst_take && word_r == 14'h0064 |-> ##2
        wdt_clr && status_out[4:3] == 2'h3) else $error("watchdog clear wrong");
    standby_entry_a: assert property (inst_take && word_r == 14'h0063 |-> ##2
        sleep_req && status_out[4:3] == 2'h2) else $error("standby wrong");
    ptr_add_a: assert property (inst_take && word_r[13:7] == 7'h62 |-> ##2
        (lat_r[6] ? ptr1_out : ptr0_out) == (lat_r[6] ? $past(ptr1_out, 2) : $past(ptr0_out, 2))
        + PTR_W'(signed'(lat_r[5:0])) && status_out == $past(status_out, 2))
        else $error("pointer add wrong");
    and_lit_a: assert property (inst_take && word_r[13:8] == 6'h39 |-> ##2
        w_out == ($past(w_out, 2) & lat_r[7:0]) && status_out == {$past(status_out[4:3], 2),
        w_out == 8'h00, $past(status_out[1:0], 2)}) else $error("and literal wrong");
    add_lit_a: assert property (inst_take && word_r[13:8] == 6'h3E |-> ##2
        {status_out[0], w_out} == 9'($past(w_out, 2)) + 9'(lat_r[7:0]) &&
        status_out[1] == ((5'($past(w_out[3:0], 2)) + lat_r[3:0]) > 5'h0F) &&
        status_out[2] == (w_out == 8'h00)) else $error("add literal wrong");
endmodule
`default_nettype wire

/* tb/cid_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cid_mem_model (
    // Clock and pacing
    input wire logic core_clk,
    input wire logic slow,
    // Program side
    input wire logic [14:0] prog_addr,
    output logic [13:0] prog_word,
    output logic prog_valid,
    // Data side
    input wire logic [15:0] dm_addr,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata,
    output logic [15:0] wr_addr
);
    logic [13:0] pmem [256] = '{default: 14'h0000};
    logic [7:0] dmem [256] = '{default: 8'h00};
    logic [1:0] gap_r = 2'h0;
    // Slow mode withholds words half the time; idle lines show inverted data
    assign prog_valid = !slow || gap_r[1];
    assign prog_word = prog_valid ? pmem[prog_addr[7:0]] : ~pmem[prog_addr[7:0]];
    assign dm_rdata = dm_rd ? dmem[dm_addr[7:0]] : ~dmem[dm_addr[7:0]];
    always @(posedge core_clk) begin
        gap_r <= gap_r + 2'h1;
        if (dm_wr) begin
            dmem[dm_addr[7:0]] <= dm_wdata;
            wr_addr <= dm_addr;
        end
    end
endmodule
`default_nettype wire

/* tb/control_and_indirect_op_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module control_and_indirect_op_decoder_tb;
    import cid_pkg::*;
    logic core_clk, rst, slow, prog_valid, inst_take, dm_rd, dm_wr, dir_wr, wdt_clr;
    logic sleep_req, soft_rst, gie_set;
    logic [13:0] prog_word;
    logic [14:0] prog_addr;
    logic [15:0] dm_addr, ptr0_out, ptr1_out, wr_addr;
    logic [7:0] dm_rdata, dm_wdata, w_out, option_out, dir_data;
    logic [4:0] status_out;
    logic [2:0] dir_sel;
    int error_cnt, n_tests, cyc, nt;
    int np [5];
    int sc [16];
    int ed [$];
    logic [7:0] sw [16];
    logic [4:0] ss [16];
    logic [14:0] sa [16];
    logic [13:0] prog_q [$];
    logic [7:0] ew [$];
    logic [4:0] es [$];
    logic [14:0] ea [$];
    wire logic [4:0] pv = {gie_set, soft_rst, sleep_req, wdt_clr, dir_wr};
    cid_core u_cid_core (.core_clk, .rst, .prog_word, .prog_valid, .prog_addr, .inst_take,
        .dm_rdata, .dm_addr, .dm_rd, .dm_wr, .dm_wdata, .w_out, .status_out, .option_out,
        .ptr0_out, .ptr1_out, .dir_wr, .dir_sel, .dir_data, .wdt_clr, .sleep_req,
        .soft_rst, .gie_set);
    cid_mem_model u_cid_mem_model (.core_clk, .slow, .prog_addr, .prog_word, .prog_valid,
        .dm_addr, .dm_rd, .dm_wr, .dm_wdata, .dm_rdata, .wr_addr);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Snapshot state at each of the first 16 fetches; count side-effect pulses
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test;
        end
        if (inst_take === 1'b1 && nt < 16) begin
            sw[nt] <= w_out;
            ss[nt] <= status_out;
            sc[nt] <= cyc;
            sa[nt] <= prog_addr - 15'h0001;
            nt <= nt + 1;
        end
        foreach (np[i]) if (pv[i] === 1'b1) np[i] <= np[i] + 1;
    end
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input int n, input logic s);
        @(posedge core_clk);
        rst <= 1'b1;
        slow <= s;
        for (int i = 0; i < 256; i++) begin
            u_cid_mem_model.pmem[i] = (i < prog_q.size()) ? prog_q[i] : 14'h0000;
        end
        repeat (2) @(posedge core_clk);
        nt = 0;
        np = '{default: 0};
        rst <= 1'b0;
        for (int k = 0; k < 400 && nt < n; k++) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        chk(nt >= n, 1'b1);
    endtask
    // Results after each op, clocks per op, fetch order
    task automatic seq;
        foreach (ew[i]) begin
            chk(sw[i + 1], ew[i]);
            if (i < es.size()) chk(ss[i + 1], es[i]);
            if (i < ed.size()) chk(sc[i + 1] - sc[i], ed[i]);
            if (i < ea.size()) chk(sa[i], ea[i]);
        end
    endtask
    task automatic t_alu;
        prog_q = {14'h3E35, 14'h3E0B, 14'h39F0, 14'h3EC0, 14'h3EFF, 14'h0521, 14'h05A2, 14'h0004};
        u_cid_mem_model.dmem[8'h21] = 8'h3C;
        u_cid_mem_model.dmem[8'h22] = 8'hC3;
        ew = {8'h35, 8'h40, 8'h40, 8'h00, 8'hFF, 8'h3C, 8'h3C, 8'h3C};
        es = {5'h18, 5'h1A, 5'h1A, 5'h1D, 5'h18, 5'h18, 5'h1C, 5'h1C};
        ed = {4, 4, 4, 4, 4, 4, 4, 4};
        ea = {};
        run(9, 1'b0);
        seq;
        chk(u_cid_mem_model.dmem[8'h22], 8'h00);
        chk(u_cid_mem_model.dmem[8'h21], 8'h3C);
    endtask
    task automatic t_ctrl;
        prog_q = {14'h3E03, 14'h000A, 14'h000B, 14'h3405, 14'h0000, 14'h0000, 14'h0000,
            14'h0000, 14'h3E08, 14'h000A, 14'h3E01, 14'h000A, 14'h0000, 14'h0008, 14'h0009};
        ew = {8'h03, 8'h03, 8'h05, 8'h05, 8'h0D, 8'h0D, 8'h0D, 8'h0E, 8'h0E, 8'h0E};
        es = {};
        ed = {4, 8, 8, 8, 4, 8, 8, 4, 8, 8};
        ea = {15'h0000, 15'h0001, 15'h0003, 15'h0002, 15'h0008, 15'h0009, 15'h000D, 15'h000A,
            15'h000B, 15'h000E};
        run(11, 1'b0);
        seq;
        chk(np[4], 1);
    endtask
    task automatic t_misc;
        prog_q = {14'h3E5A, 14'h0062, 14'h0065, 14'h0063, 14'h0064, 14'h0001, 14'h0004};
        ew = {8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A};
        es = {5'h18, 5'h18, 5'h18, 5'h10, 5'h18, 5'h18, 5'h18};
        ed = {};
        ea = {};
        run(8, 1'b1);
        seq;
        chk(option_out, 8'h5A);
        chk(np[0], 1);
        chk(np[1], 1);
        chk(np[2], 1);
        chk({dir_sel, dir_data}, {3'h5, 8'h5A});
        chk(np[3], 1);
    endtask
    task automatic t_ptr;
        prog_q = {14'h3101, 14'h3160, 14'h3E77, 14'h0018, 14'h0012, 14'h3F05, 14'h3E42,
            14'h3FC1, 14'h0017, 14'h311F, 14'h0015};
        u_cid_mem_model.dmem[8'h08] = 8'h00;
        u_cid_mem_model.dmem[8'hE0] = 8'h81;
        u_cid_mem_model.dmem[8'hDE] = 8'h00;
        ew = {8'h00, 8'h00, 8'h77, 8'h77, 8'h77, 8'h00, 8'h42, 8'h42, 8'h81, 8'h81, 8'h00};
        es = {5'h18, 5'h18, 5'h18, 5'h18, 5'h18, 5'h1C, 5'h18, 5'h18, 5'h18, 5'h18, 5'h1C};
        ed = {4, 4, 4, 4, 4, 4, 4, 8, 8, 4, 8};
        ea = {};
        run(12, 1'b0);
        seq;
        chk(ptr0_out, 16'h0022);
        chk(ptr1_out, 16'hFFDE);
        chk(u_cid_mem_model.dmem[8'h02], 8'h77);
        chk({wr_addr, u_cid_mem_model.dmem[8'hE1]}, {16'hFFE1, 8'h42});
    endtask
    initial begin
        rst = 1'b1;
        slow = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        nt = 0;
        t_alu;
        t_ctrl;
        t_misc;
        t_ptr;
        end_of_test;
    end
endmodule
bind cid_core cid_monitor #(.PTR_W(PTR_W)) u_cid_monitor (.core_clk, .rst, .prog_word,
    .inst_take, .dm_addr, .dm_rd, .dm_wr, .w_out, .status_out, .option_out, .ptr0_out,
    .ptr1_out, .dir_wr, .dir_sel, .dir_data, .wdt_clr, .sleep_req);
`default_nettype wire
